// >>> logic/iilr_regs.svh
/*
 iilr_regs.svh: timing figures, message layout and counts of the line relay.
 assumes: included by bare name from files inside logic/.
*/
`ifndef IILR_REGS_SVH
`define IILR_REGS_SVH

`define IILR_CLK_NS      25
`define IILR_IDLE_NS     115000
`define IILR_STUCK_NS    37000000
`define IILR_REFRESH_NS  1150000
`define IILR_RECOV_NS    40000
`define IILR_HALF_NS     5000
`define IILR_RCV_PULSES  4'hf
`define IILR_MSG_BITS    3
`define IILR_MSG_SDA     2
`define IILR_MSG_SCL     1
`define IILR_MSG_STUCK   0
`define IILR_BIT_PW      2'h2
`define IILR_BIT_LAST    2'h3
`define IILR_RX_TMO      5'h10
`define IILR_SDA         0
`define IILR_SCL         1

`endif

// >>> logic/iilr_pkg.sv
/*
 iilr_pkg: state types of the line relay.
 assumes: compiled before the relay modules.
*/
`default_nettype none
package iilr_pkg;
    typedef enum logic [2:0] {ST_POR, ST_WAIT, ST_LINK, ST_STUCK, ST_CLOCKS, ST_STOP} iilr_state_e;
    typedef enum logic [1:0] {LN_EXT_HI, LN_EXT_LO, LN_RISE} iilr_line_e;
endpackage
`default_nettype wire

// >>> logic/iilr_line_sense.sv
/*
 iilr_line_sense: external-state detection and edge control for one bus line.
 assumes: all inputs already synchronised to clk_i; outputs registered by the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module iilr_line_sense
    import iilr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic active_i,
    input  wire logic drive_req_i,
    input  wire logic line_hi_i,
    input  wire logic thr_lo_i,
    input  wire logic thr_hi_i,
    input  wire logic below_own_i,
    input  wire logic rising_i,
    input  wire logic slow_rise_i,
    output logic      ext_low_o,
    output logic      drive_o,
    output logic      limiter_o,
    output logic      accel_o
);
    iilr_line_e st;
    iilr_line_e next_st;
    logic [2:0] echo;
    logic [2:0] next_echo;
    logic       own;
    // own release reaches the synced levels three cycles late
    assign own = drive_req_i | (|echo);

    always_comb begin
        next_echo = active_i ? {echo[1:0], drive_req_i} : 3'h0;
        next_st = st;
        if (!active_i) begin
            next_st = line_hi_i ? LN_EXT_HI : LN_EXT_LO;
        end else begin
            case (st)
                LN_EXT_HI: begin
                    if (own) begin
                        if (below_own_i) next_st = LN_EXT_LO;
                    end else if (!thr_hi_i && !rising_i) begin
                        next_st = LN_EXT_LO;
                    end
                end
                LN_EXT_LO: begin
                    // own drive: only a deeper pull counts
                    if (own) begin
                        if (!below_own_i) next_st = LN_EXT_HI;
                    end else if (rising_i) begin
                        next_st = LN_RISE;
                    end
                end
                LN_RISE: begin
                    if (slow_rise_i) next_st = LN_EXT_LO;
                    else if (!rising_i) next_st = line_hi_i ? LN_EXT_HI : LN_EXT_LO;
                end
                default: next_st = LN_EXT_HI;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st   <= LN_EXT_HI;
            echo <= 3'h0;
        end else if (ce_i) begin
            st   <= next_st;
            echo <= next_echo;
        end
    end

    assign ext_low_o = (st == LN_EXT_LO);
    assign drive_o   = active_i & drive_req_i;
    assign limiter_o = active_i & (st == LN_RISE) & !thr_lo_i;
    // accelerator only once limiter is off
    assign accel_o   = active_i & (st == LN_RISE) & thr_lo_i & thr_hi_i;
endmodule
`default_nettype wire

// >>> logic/iilr_line_relay.sv
/*
 iilr_line_relay: control logic of one half of an isolated two-wire bus repeater.
 assumes: one 40 MHz clk_i; comparators and peer pulses arrive async; pins resolved outside.
*/
// Functional notes
// - enable high: carry line states both ways
// - enable low: link silent, all functions off
// - ready low only while linked
// - report only externally driven line states while linked
// - external fall on data: peer drives low
// - hold low for peer; deeper pull reports low
// - release: limiter on, send high
// - slow rise means new pull-down: send low
// - limiter off above lower threshold
// - accelerator on above upper threshold
// - reset hold until enable, no thermal, supply
// - after reset, watch quiet on both buses
// - both quiet: connect and assert ready
// - low for stuck interval: disconnect
// - stuck bus releases ready high
// - reconnect only after next joint quiet
// - quiet: idle interval high or STOP since
// - stuck timer runs while any line low
// - send on change; resend after refresh interval
// - after delay, up to sixteen clocks, then STOP
`timescale 1ns/1ps
`default_nettype none
`include "iilr_regs.svh"
module iilr_line_relay
    import iilr_pkg::*;
#(
    parameter int unsigned IDLE_CYC    = (`IILR_IDLE_NS + `IILR_CLK_NS - 1) / `IILR_CLK_NS,
    parameter int unsigned STUCK_CYC   = (`IILR_STUCK_NS + `IILR_CLK_NS - 1) / `IILR_CLK_NS,
    parameter int unsigned REFRESH_CYC = `IILR_REFRESH_NS / `IILR_CLK_NS
)
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       enable_i,
    input  wire logic       therm_shdn_i,
    input  wire logic       supply_low_lockout_i,
    input  wire logic [1:0] line_hi_i,
    input  wire logic [1:0] thr_lo_i,
    input  wire logic [1:0] thr_hi_i,
    input  wire logic [1:0] below_own_i,
    input  wire logic [1:0] rising_i,
    input  wire logic [1:0] slow_rise_i,
    input  wire logic       link_in_pos_i,
    input  wire logic       link_in_neg_i,
    output logic      [1:0] bus_out_o,
    output logic      [1:0] bus_oe_n_o,
    output logic            ready_out_o,
    output logic            ready_oe_n_o,
    output logic            link_out_pos_o,
    output logic            link_out_neg_o,
    output logic      [1:0] limiter_en_o,
    output logic      [1:0] accel_en_o
);
    localparam int unsigned RECOV_CYC = (`IILR_RECOV_NS + `IILR_CLK_NS - 1) / `IILR_CLK_NS;
    localparam int unsigned HALF_CYC  = `IILR_HALF_NS / `IILR_CLK_NS;
    localparam int unsigned SW = $clog2(STUCK_CYC + 1);
    localparam int unsigned IW = $clog2(IDLE_CYC + 1);
    localparam int unsigned FW = $clog2(REFRESH_CYC + 1);
    localparam int unsigned TW = $clog2(RECOV_CYC + 1);
    localparam int unsigned NS = 17;

    // every pin level passes two flops before use
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1 <= '0;
            s2 <= '0;
        end else if (ce_i) begin
            s1 <= {enable_i, therm_shdn_i, supply_low_lockout_i, link_in_pos_i, link_in_neg_i,
                   line_hi_i, thr_lo_i, thr_hi_i, below_own_i, rising_i, slow_rise_i};
            s2 <= s1;
        end
    end
    logic       en_s, th_s, uv_s, pos_s, neg_s;
    logic [1:0] hi_s, lo_s, up_s, bo_s, ri_s, sr_s;
    assign {en_s, th_s, uv_s, pos_s, neg_s, hi_s, lo_s, up_s, bo_s, ri_s, sr_s} = s2;

    logic run;
    assign run = en_s & !th_s & !uv_s;

    iilr_state_e st, next_st;
    logic [SW-1:0] stk, next_stk;
    logic [TW-1:0] tmr, next_tmr;
    logic [3:0]    pul, next_pul;
    logic          ph, next_ph;
    logic [1:0]    rcv_drv, next_rcv_drv;
    logic          rx_sda, rx_scl, rx_stuck;
    logic [1:0]    quiet;
    logic          linked;
    assign linked = (st == ST_LINK);

    // main sequence: reset hold, wait for quiet, linked, stuck recovery
    always_comb begin
        next_st      = st;
        next_stk     = '0;
        next_tmr     = tmr;
        next_pul     = pul;
        next_ph      = ph;
        next_rcv_drv = '0;
        case (st)
            ST_POR: begin
                if (run) next_st = ST_WAIT;
            end
            ST_WAIT: begin
                if (&quiet) next_st = ST_LINK;
            end
            ST_LINK: begin
                if (!(&hi_s)) next_stk = stk + SW'(1);
                if (stk == SW'(STUCK_CYC)) begin
                    next_st  = ST_STUCK;
                    next_tmr = '0;
                end else if (rx_stuck) begin
                    next_st = ST_WAIT;
                end
            end
            ST_STUCK: begin
                next_tmr = tmr + TW'(1);
                if (tmr == TW'(RECOV_CYC)) begin
                    next_st  = ST_CLOCKS;
                    next_tmr = '0;
                    next_pul = '0;
                    next_ph  = 1'b0;
                end
            end
            ST_CLOCKS: begin
                next_rcv_drv[`IILR_SCL] = !ph;
                next_tmr = tmr + TW'(1);
                if (tmr == TW'(HALF_CYC)) begin
                    next_tmr = '0;
                    next_ph  = !ph;
                    if (ph) begin
                        next_pul = pul + 4'h1;
                        // stop early once data has let go
                        if (hi_s[`IILR_SDA] || pul == `IILR_RCV_PULSES) begin
                            next_st = ST_STOP;
                            next_ph = 1'b0;
                        end
                    end
                end
            end
            ST_STOP: begin
                next_rcv_drv[`IILR_SDA] = !ph;
                next_tmr = tmr + TW'(1);
                if (tmr == TW'(HALF_CYC)) begin
                    next_tmr = '0;
                    next_ph  = 1'b1;
                    if (ph) next_st = ST_WAIT;
                end
            end
            default: next_st = ST_POR;
        endcase
        if (!run) begin
            next_st      = ST_POR;
            next_rcv_drv = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st      <= ST_POR;
            stk     <= '0;
            tmr     <= '0;
            pul     <= '0;
            ph      <= 1'b0;
            rcv_drv <= '0;
        end else if (ce_i) begin
            st      <= next_st;
            stk     <= next_stk;
            tmr     <= next_tmr;
            pul     <= next_pul;
            ph      <= next_ph;
            rcv_drv <= next_rcv_drv;
        end
    end

    // quiet detection: bus 0 local, bus 1 the peer's as received
    logic [1:0] q_sda, q_scl;
    assign q_sda = {rx_sda, hi_s[`IILR_SDA]};
    assign q_scl = {rx_scl, hi_s[`IILR_SCL]};
    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_quiet
            logic [IW-1:0] icnt, next_icnt;
            logic          stp, next_stp, psda, next_psda;
            always_comb begin
                next_psda = q_sda[b];
                next_icnt = '0;
                next_stp  = stp;
                if (q_sda[b] && q_scl[b] && icnt != IW'(IDLE_CYC)) next_icnt = icnt + IW'(1);
                else if (q_sda[b] && q_scl[b]) next_icnt = icnt;
                if (q_sda[b] && !psda && q_scl[b]) next_stp = 1'b1;
                else if (!(q_sda[b] && q_scl[b])) next_stp = 1'b0;
                if (st == ST_POR) begin
                    next_icnt = '0;
                    next_stp  = 1'b0;
                end
            end
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    icnt <= '0;
                    stp  <= 1'b0;
                    psda <= 1'b1;
                end else if (ce_i) begin
                    icnt <= next_icnt;
                    stp  <= next_stp;
                    psda <= next_psda;
                end
            end
            assign quiet[b] = (icnt == IW'(IDLE_CYC)) | stp;
        end
    endgenerate

    // per-line sensing, data and clock alike
    logic [1:0] ext_low, sdrv, lim, acc, rx_low;
    assign rx_low = {!rx_scl, !rx_sda};
    genvar l;
    generate
        for (l = 0; l < 2; l++) begin : g_line
            iilr_line_sense u_sense (
                .clk_i       (clk_i),
                .rst_n_i     (rst_n_i),
                .ce_i        (ce_i),
                .active_i    (linked),
                .drive_req_i (rx_low[l]),
                .line_hi_i   (hi_s[l]),
                .thr_lo_i    (lo_s[l]),
                .thr_hi_i    (up_s[l]),
                .below_own_i (bo_s[l]),
                .rising_i    (ri_s[l]),
                .slow_rise_i (sr_s[l]),
                .ext_low_o   (ext_low[l]),
                .drive_o     (sdrv[l]),
                .limiter_o   (lim[l]),
                .accel_o     (acc[l])
            );
        end
    endgenerate

    // transmit: message change or refresh starts a three-bit frame
    logic [2:0]    msg, last, sh, next_last, next_sh;
    logic [FW-1:0] ref_cnt, next_ref_cnt;
    logic          pend, busy, next_pend, next_busy, start, next_pos, next_neg;
    logic [1:0]    bidx, bph, next_bidx, next_bph;
    logic          stuck_msg;
    assign stuck_msg = (st == ST_STUCK) | (st == ST_CLOCKS) | (st == ST_STOP);
    // unlinked: raw levels sent, own recovery clocks and STOP included
    assign msg = {linked ? !ext_low[`IILR_SDA] : hi_s[`IILR_SDA],
                  linked ? !ext_low[`IILR_SCL] : hi_s[`IILR_SCL], stuck_msg};
    assign start = pend & !busy;

    always_comb begin
        next_ref_cnt = ref_cnt + FW'(1);
        next_last    = last;
        next_sh      = sh;
        next_bidx    = bidx;
        next_bph     = bph;
        next_busy    = busy;
        // event in start cycle stays pending
        next_pend    = pend & !start;
        if (msg != last || ref_cnt == FW'(REFRESH_CYC)) begin
            next_pend    = 1'b1;
            next_last    = msg;
            next_ref_cnt = '0;
        end
        if (start) begin
            next_sh   = last;
            next_busy = 1'b1;
            next_bidx = '0;
            next_bph  = '0;
        end else if (busy) begin
            next_bph = bph + 2'h1;
            if (bph == `IILR_BIT_LAST) begin
                next_sh   = {sh[1:0], 1'b0};
                next_bidx = bidx + 2'h1;
                if (bidx == 2'(`IILR_MSG_BITS - 1)) next_busy = 1'b0;
            end
        end
        next_pos = busy & (bph < `IILR_BIT_PW) & sh[2];
        next_neg = busy & (bph < `IILR_BIT_PW) & !sh[2];
        if (st == ST_POR) begin
            next_pend    = 1'b0;
            next_busy    = 1'b0;
            next_pos     = 1'b0;
            next_neg     = 1'b0;
            next_ref_cnt = '0;
            next_last    = 3'h6;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt        <= '0;
            last           <= 3'h6;
            sh             <= '0;
            bidx           <= '0;
            bph            <= '0;
            busy           <= 1'b0;
            pend           <= 1'b0;
            link_out_pos_o <= 1'b0;
            link_out_neg_o <= 1'b0;
        end else if (ce_i) begin
            ref_cnt        <= next_ref_cnt;
            last           <= next_last;
            sh             <= next_sh;
            bidx           <= next_bidx;
            bph            <= next_bph;
            busy           <= next_busy;
            pend           <= next_pend;
            link_out_pos_o <= next_pos;
            link_out_neg_o <= next_neg;
        end
    end

    // receive: pulse rising edges are bits; silence resyncs
    logic       pos_d, neg_d, next_rx_sda, next_rx_scl, next_rx_stuck;
    logic [1:0] rsh, next_rsh, rcnt, next_rcnt;
    logic [4:0] rto, next_rto;
    logic       bit_pos, bit_neg;
    assign bit_pos = pos_s & !pos_d;
    assign bit_neg = neg_s & !neg_d;

    always_comb begin
        next_rsh      = rsh;
        next_rcnt     = rcnt;
        next_rx_sda   = rx_sda;
        next_rx_scl   = rx_scl;
        next_rx_stuck = rx_stuck;
        next_rto      = (rto == `IILR_RX_TMO) ? rto : rto + 5'h1;
        if (rto == `IILR_RX_TMO) next_rcnt = '0;
        if (bit_pos || bit_neg) begin
            next_rto  = '0;
            next_rsh  = {rsh[0], bit_pos};
            next_rcnt = rcnt + 2'h1;
            if (rcnt == 2'(`IILR_MSG_BITS - 1)) begin
                next_rcnt     = '0;
                next_rx_sda   = rsh[1];
                next_rx_scl   = rsh[0];
                next_rx_stuck = bit_pos;
            end
        end
        if (st == ST_POR) begin
            next_rcnt     = '0;
            next_rx_sda   = 1'b1;
            next_rx_scl   = 1'b1;
            next_rx_stuck = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_d    <= 1'b0;
            neg_d    <= 1'b0;
            rsh      <= '0;
            rcnt     <= '0;
            rto      <= '0;
            rx_sda   <= 1'b1;
            rx_scl   <= 1'b1;
            rx_stuck <= 1'b0;
        end else if (ce_i) begin
            pos_d    <= pos_s;
            neg_d    <= neg_s;
            rsh      <= next_rsh;
            rcnt     <= next_rcnt;
            rto      <= next_rto;
            rx_sda   <= next_rx_sda;
            rx_scl   <= next_rx_scl;
            rx_stuck <= next_rx_stuck;
        end
    end

    // pin stage: open drain, enable low while pulling down
    logic [1:0] next_oe_n;
    assign next_oe_n = ~(sdrv | rcv_drv);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_out_o    <= '0;
            bus_oe_n_o   <= 2'h3;
            ready_out_o  <= 1'b0;
            ready_oe_n_o <= 1'b1;
            limiter_en_o <= '0;
            accel_en_o   <= '0;
        end else if (ce_i) begin
            bus_out_o    <= '0;
            bus_oe_n_o   <= next_oe_n;
            ready_out_o  <= 1'b0;
            ready_oe_n_o <= !(linked && next_st == ST_LINK);
            limiter_en_o <= lim;
            accel_en_o   <= acc;
        end
    end
endmodule
`default_nettype wire

// >>> tb/iilr_line_relay_asserts.sv
/*
 iilr_line_relay_asserts: port checks of the line relay.
 assumes: bound to iilr_line_relay, one clock, pins resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module iilr_line_relay_asserts #(
    parameter int unsigned STUCK_CYC = 200
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       enable_i,
    input wire logic [1:0] line_hi_i,
    input wire logic [1:0] thr_lo_i,
    input wire logic [1:0] thr_hi_i,
    input wire logic [1:0] bus_out_o,
    input wire logic [1:0] bus_oe_n_o,
    input wire logic       ready_out_o,
    input wire logic       ready_oe_n_o,
    input wire logic       link_out_pos_o,
    input wire logic       link_out_neg_o,
    input wire logic [1:0] limiter_en_o,
    input wire logic [1:0] accel_en_o
);
    int unsigned off_cnt, low_cnt, hi_cnt;
    // saturate so long runs never wrap
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            off_cnt <= 0;
            low_cnt <= 0;
            hi_cnt <= 0;
        end else begin
            off_cnt <= enable_i ? 0 : off_cnt + (off_cnt < 31);
            low_cnt <= &line_hi_i ? 0 : low_cnt + (low_cnt < 99999);
            hi_cnt <= &line_hi_i ? hi_cnt + (hi_cnt < 99) : 0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // 16 covers sync flops and a frame in flight
    a_off_all_quiet: assert property (off_cnt >= 16 |-> ready_oe_n_o && bus_oe_n_o == 2'h3
        && !link_out_pos_o && !link_out_neg_o && limiter_en_o == 2'h0 && accel_en_o == 2'h0)
        else $error("outputs active while disabled");
    a_pos_pulse: assert property ($rose(link_out_pos_o) |=> link_out_pos_o ##1 !link_out_pos_o)
        else $error("positive pulse width wrong");
    a_neg_pulse: assert property ($rose(link_out_neg_o) |-> link_out_neg_o [*2] ##1 !link_out_neg_o)
        else $error("negative pulse width wrong");
    a_one_rail: assert property (!(link_out_pos_o && link_out_neg_o))
        else $error("both link rails high");
    a_open_drain: assert property (bus_out_o == 2'h0 && ready_out_o == 1'b0)
        else $error("open-drain pin driven high");
    a_accel_excl: assert property ((accel_en_o & limiter_en_o) == 2'h0)
        else $error("accelerator on with limiter");
    a_lim_off_data: assert property (thr_lo_i[0] [*4] |-> !limiter_en_o[0])
        else $error("data limiter above threshold");
    a_lim_off_clk: assert property (thr_lo_i[1] [*4] |-> !limiter_en_o[1])
        else $error("clock limiter above threshold");
    a_accel_needs_hi: assert property (!thr_hi_i[0] [*4] |-> !accel_en_o[0])
        else $error("accelerator on below threshold");
    a_stuck_drop: assert property (low_cnt > STUCK_CYC + 6 |-> ready_oe_n_o)
        else $error("ready held on stuck bus");
    a_link_quiet: assert property ($fell(ready_oe_n_o) |-> hi_cnt >= 2 && $past(enable_i, 3))
        else $error("linked without quiet bus");
endmodule
bind iilr_line_relay iilr_line_relay_asserts #(.STUCK_CYC(STUCK_CYC)) u_chk (.*);
`default_nettype wire

// >>> tb/iilr_peer_model.sv
/*
 iilr_peer_model: far half of the barrier link, sends and decodes 3-bit frames.
 assumes: shares clk_i with the relay; link rails idle low between pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module iilr_peer_model (
    input  wire logic        clk_i,
    input  wire logic        link_pos_i,
    input  wire logic        link_neg_i,
    output logic             link_pos_o,
    output logic             link_neg_o,
    output logic [2:0]       rx_msg_o,
    output var int unsigned  rx_cnt_o
);
    logic       p_q = 1'b0;
    logic       n_q = 1'b0;
    logic [2:0] sh = 3'h0;
    int         nb = 0;
    int         idle = 0;
    initial begin
        link_pos_o = 1'b0;
        link_neg_o = 1'b0;
        rx_msg_o = 3'h0;
        rx_cnt_o = 0;
    end
    // long gap drops partial frames
    always @(posedge clk_i) begin
        idle = idle + 1;
        if (idle > 16) nb = 0;
        if ((link_pos_i && !p_q) || (link_neg_i && !n_q)) begin
            idle = 0;
            sh = {sh[1:0], link_pos_i};
            nb = nb + 1;
            if (nb == 3) begin
                nb = 0;
                rx_msg_o <= sh;
                rx_cnt_o <= rx_cnt_o + 1;
            end
        end
        p_q = link_pos_i;
        n_q = link_neg_i;
    end
    // msb first; 2 high, 2 low per bit
    task automatic send(input logic [2:0] m);
        for (int b = 2; b >= 0; b--) begin
            @(posedge clk_i);
            #2;
            link_pos_o = m[b];
            link_neg_o = !m[b];
            repeat (2) @(posedge clk_i);
            #2;
            link_pos_o = 1'b0;
            link_neg_o = 1'b0;
            @(posedge clk_i);
        end
        #2;
    endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
/*
 testbench: self-checking bench of the line relay with a peer model.
 assumes: shortened timing parameters; bus wires resolved here from pull-downs.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int IDLE = 20, STUCK = 200, REFR = 100;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, enable = 1'b0, therm = 1'b0, lock = 1'b0;
    logic [1:0]  line_r = 2'h3, lo_r = 2'h3, hi_r = 2'h3, rise_r = 2'h0, below_r = 2'h0, slow_r = 2'h0;
    logic [1:0]  bus_out, oe_n, lim, acc;
    logic        rdy, rdy_oe_n, lp, ln, ip, in_n, prev, stop_seen;
    logic [2:0]  rx_msg, m, lo;
    int unsigned rx_cnt, n0;
    int          failures = 0, checks = 0, cycles = 0, n, k, m_link = 0;
    logic [2:0]  sent_q[$];
    always #12.5 clk_i = ~clk_i;
    // wire low when anyone pulls it
    iilr_line_relay #(.IDLE_CYC(IDLE), .STUCK_CYC(STUCK), .REFRESH_CYC(REFR)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .enable_i(enable), .therm_shdn_i(therm),
        .supply_low_lockout_i(lock), .line_hi_i(line_r & oe_n), .thr_lo_i(lo_r & oe_n),
        .thr_hi_i(hi_r & oe_n), .below_own_i(below_r), .rising_i(rise_r), .slow_rise_i(slow_r),
        .link_in_pos_i(ip), .link_in_neg_i(in_n), .bus_out_o(bus_out), .bus_oe_n_o(oe_n),
        .ready_out_o(rdy), .ready_oe_n_o(rdy_oe_n), .link_out_pos_o(lp), .link_out_neg_o(ln),
        .limiter_en_o(lim), .accel_en_o(acc));
    iilr_peer_model peer (.clk_i(clk_i), .link_pos_i(lp), .link_neg_i(ln), .link_pos_o(ip),
        .link_neg_o(in_n), .rx_msg_o(rx_msg), .rx_cnt_o(rx_cnt));
    function automatic logic [1:0] exp_oe(input logic [2:0] msg);
        return (m_link != 0) ? {msg[1], msg[2]} : 2'h3;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
        #2;
    endtask
    task automatic wait_msg(input logic [2:0] w, input int lim_c);
        n = 0;
        while (rx_msg !== w && n < lim_c) begin
            cyc(1);
            n++;
        end
        chk("peer message", 8'(rx_msg), 8'(w));
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // whole run is about 10k cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        void'($urandom(83650));
        cyc(20);
        rst_n_i = 1'b1;
        cyc(30);
        chk("ready off", 8'(rdy_oe_n), 8'h1);
        chk("bus off", 8'(oe_n), 8'h3);
        enable = 1'b1;
        therm = 1'b1;
        cyc(30);
        chk("thermal hold", 8'(rx_cnt), 8'h0);
        therm = 1'b0;
        lock = 1'b1;
        cyc(30);
        chk("lockout hold", 8'(rx_cnt), 8'h0);
        lock = 1'b0;
        $display("test hold-off done");
        wait_msg(3'h6, REFR + 40);
        peer.send(3'h6);
        cyc(IDLE + 40);
        chk("linked", 8'(rdy_oe_n), 8'h0);
        m_link = 1;
        $display("test link done");
        repeat (8) begin
            m = 3'($urandom_range(3)) << 1;
            sent_q.push_back(m);
            peer.send(m);
            cyc(6);
            chk("peer drive", 8'(oe_n), 8'(exp_oe(sent_q.pop_front())));
            chk("own low hidden", 8'(rx_msg), 8'h6);
        end
        peer.send(3'h6);
        peer.send(3'h2);
        cyc(6);
        below_r[0] = 1'b1;
        wait_msg(3'h2, 40);
        below_r[0] = 1'b0;
        peer.send(3'h6);
        rise_r[0] = 1'b1;
        cyc(4);
        rise_r[0] = 1'b0;
        wait_msg(3'h6, 60);
        $display("test peer drive done");
        for (int i = 0; i < 2; i++) begin
            lo = 3'h6 & ~(3'h4 >> i);
            line_r[i] = 1'b0;
            lo_r[i] = 1'b0;
            hi_r[i] = 1'b0;
            wait_msg(lo, 40);
            rise_r[i] = 1'b1;
            wait_msg(3'h6, 40);
            chk("limiter on", 8'(lim[i]), 8'h1);
            slow_r[i] = 1'b1;
            wait_msg(lo, 40);
            slow_r[i] = 1'b0;
            wait_msg(3'h6, 40);
            lo_r[i] = 1'b1;
            cyc(6);
            chk("limiter off", 8'(lim[i]), 8'h0);
            hi_r[i] = 1'b1;
            line_r[i] = 1'b1;
            cyc(6);
            chk("accel on", 8'(acc[i]), 8'h1);
            rise_r[i] = 1'b0;
            cyc(20);
        end
        $display("test edges done");
        n0 = rx_cnt;
        cyc(REFR + 30);
        chk("refresh sent", 8'(rx_cnt != n0), 8'h1);
        chk("refresh value", 8'(rx_msg), 8'h6);
        $display("test refresh done");
        line_r[0] = 1'b0;
        lo_r[0] = 1'b0;
        hi_r[0] = 1'b0;
        cyc(STUCK + 20);
        chk("stuck ready", 8'(rdy_oe_n), 8'h1);
        wait_msg(3'h3, 60);
        k = 0;
        stop_seen = 1'b0;
        repeat (9000) begin
            prev = oe_n[1];
            cyc(1);
            if (prev && !oe_n[1]) k++;
            if (k == 16 && !oe_n[0]) stop_seen = 1'b1;
        end
        chk("recovery clocks", 8'(k), 8'h10);
        chk("recovery stop", 8'(stop_seen), 8'h1);
        chk("no relink low", 8'(rdy_oe_n), 8'h1);
        line_r[0] = 1'b1;
        lo_r[0] = 1'b1;
        hi_r[0] = 1'b1;
        cyc(IDLE + 40);
        chk("relinked", 8'(rdy_oe_n), 8'h0);
        $display("test stuck done");
        enable = 1'b0;
        cyc(20);
        chk("shutdown ready", 8'(rdy_oe_n), 8'h1);
        n0 = rx_cnt;
        cyc(REFR + 30);
        chk("shutdown silent", 8'(rx_cnt == n0), 8'h1);
        $display("test shutdown done");
        results();
    end
endmodule
`default_nettype wire
